// [rtl/pbc_base_clock_selector.sv]
// PLL setting store, power and source interlocks, and base clock selection
`timescale 1ns/1ps

// Notes on behaviour
// - Select bit chooses crystal or VCO source
// - Switch waits three edges per source, output held
// - Switched clock divided by two
// - No VCO selection while PLL is off
// - No power-off while VCO is selected
// - Power change and select change never together
// - Zero linear range disables PLL, forces crystal
// - Zero divider or multiplier acts as one
// - Ratio is N times two to P; output is that over R
// - Select reads zero when off or L zero
// - Power reads one while select is set
// - Programming values frozen while PLL is on
module pbc_base_clock_selector (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic crystalClock,
	input wire logic vcoClock,
	input wire logic ctrlWrite,
	input wire pbc_pkg::pbc_ctrl_t ctrlData,
	input wire logic multLowWrite,
	input wire logic multHighWrite,
	input wire logic rangeWrite,
	input wire logic refDivWrite,
	input wire logic [pbc_pkg::BYTE_W-1:0] writeData,
	output pbc_pkg::pbc_ctrl_t ctrlRead,
	output logic [pbc_pkg::BYTE_W-1:0] multLowRead,
	output logic [pbc_pkg::BYTE_W-1:0] multHighRead,
	output logic [pbc_pkg::BYTE_W-1:0] rangeRead,
	output logic [pbc_pkg::BYTE_W-1:0] refDivRead,
	output pbc_pkg::pbc_loop_t loopSettings,
	output logic baseClockOut,
	output logic vcoActive,
	output logic switchBusy
);
	import pbc_pkg::*;

	// The block is a small register file with two interlocked control bits.
	// Software sees only the read-back views, which apply the forcing at once.
	// The stored select may lag its view by one cycle while hardware clears it.
	// Nothing reports a refused write, so software must read back to confirm.
	// The analog loop itself sits outside; only its settings are kept here.

	// Stored control bits and the live programming values
	logic pllPowerOn;
	logic baseClockSelect;
	pbc_settings_t settings;
	logic linearZero;
	logic powerChange;
	// Next values of the two control bits
	logic next_pllPowerOn;
	logic next_baseClockSelect;
	logic programOpen;

	// Zero in a divider field means divide by one.
	// eff_mult is used by both the loop outputs and the ratio, so kept as functions
	// rather than repeated expressions.
	function automatic logic [MULT_W-1:0] eff_mult(input logic [MULT_W-1:0] v);
		eff_mult = (v == '0) ? MULT_W'(1) : v;
	endfunction : eff_mult

	function automatic logic [REFDIV_W-1:0] eff_div(input logic [REFDIV_W-1:0] v);
		eff_div = (v == '0) ? REFDIV_W'(1) : v;
	endfunction : eff_div

	// Zero range disables the loop
	assign linearZero = (settings.linearRange == '0);

	// Programming values are only open while the PLL is powered down.
	// Changing a divider under a running loop would throw it out of lock,
	// so every programming write is gated by the stored power bit.
	assign programOpen = ~pllPowerOn;

	// Power bit: a set select bit pins it on, so power-off is refused.
	// Refusing the write outright keeps the VCO alive while it still drives
	// the base clock; software must deselect first and wait for the switch.
	always_comb begin
		next_pllPowerOn = pllPowerOn;
		if (ctrlWrite && !baseClockSelect) begin
			next_pllPowerOn = ctrlData.pllPowerOn;
		end
	end

	// Power moves only when the write is not refused
	assign powerChange = (next_pllPowerOn != pllPowerOn);

	// Select bit: a write that also changes power leaves the select untouched.
	// Power and source never move in one write, so the loop is never asked to
	// start and carry the bus clock at once. The clear at the end wins over
	// any write, so a zero range or an unpowered loop can never be selected.
	always_comb begin
		next_baseClockSelect = baseClockSelect;
		if (ctrlWrite) begin
			if (powerChange) begin
				next_baseClockSelect = baseClockSelect;
			end else if (!pllPowerOn || linearZero) begin
				next_baseClockSelect = 1'b0;
			end else begin
				next_baseClockSelect = ctrlData.baseClockSelect;
			end
		end
		// Held clear whenever the PLL cannot supply a clock
		if (!pllPowerOn || linearZero) begin
			next_baseClockSelect = 1'b0;
		end
	end

	// Control bits; reset leaves the loop powered but the crystal selected.
	// The crystal stays the source until software selects the VCO.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pllPowerOn <= RST_POWER_ON;
			baseClockSelect <= RST_BASE_SELECT;
		end else begin
			pllPowerOn <= next_pllPowerOn;
			baseClockSelect <= next_baseClockSelect;
		end
	end

	// Prescaler and range power share the control write but freeze with the PLL on.
	// The freeze uses the stored power bit, so a power-off write cannot also
	// reprogram P and E; a second write is needed once the loop is down.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settings.prescaler <= RST_PRESCALE;
			settings.rangePower <= RST_RANGE_POW;
		end else if (ctrlWrite && programOpen) begin
			settings.prescaler <= ctrlData.prescaler;
			settings.rangePower <= ctrlData.rangePower;
		end
	end

	// Multiplier halves; upper bits of the high byte are not stored.
	// The halves are written one at a time; the loop sees the mixed value in
	// between, which is harmless because the loop is off while they are open.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settings.multiplier <= RST_MULT;
		end else if (programOpen) begin
			if (multLowWrite) begin
				settings.multiplier[MULT_HIGH_LSB-1:MULT_LOW_LSB] <= writeData;
			end
			if (multHighWrite) begin
				settings.multiplier[MULT_W-1:MULT_HIGH_LSB] <=
					writeData[MULT_HIGH_W-1:0];
			end
		end
	end

	// Linear range multiplier
	// A zero here disables the loop and blocks VCO selection downstream.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settings.linearRange <= RST_LINEAR;
		end else if (rangeWrite && programOpen) begin
			settings.linearRange <= writeData;
		end
	end

	// Reference divider
	// Only the low four bits are stored; a zero acts as a divide by one.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settings.refDivider <= RST_REFDIV;
		end else if (refDivWrite && programOpen) begin
			settings.refDivider <= writeData[REFDIV_W-1:0];
		end
	end

	// Read-back views; unimplemented bits read as zero.
	// Power reads as set while the select is set, and the select reads as clear
	// whenever the loop cannot supply a clock, even before hardware clears it.
	always_comb begin
		ctrlRead.pllPowerOn = pllPowerOn | baseClockSelect;
		ctrlRead.baseClockSelect = baseClockSelect & pllPowerOn & ~linearZero;
		ctrlRead.prescaler = settings.prescaler;
		ctrlRead.rangePower = settings.rangePower;
	end

	// Register views padded to a byte; unused upper bits are zero
	assign multLowRead = settings.multiplier[MULT_HIGH_LSB-1:MULT_LOW_LSB];
	assign multHighRead = {(BYTE_W - MULT_HIGH_W)'(0), settings.multiplier[MULT_W-1:MULT_HIGH_LSB]};
	assign rangeRead = settings.linearRange;
	assign refDivRead = {(BYTE_W - REFDIV_W)'(0), settings.refDivider};

	// Loop settings are registered so the analog side sees clean levels.
	// Ratio is the feedback divide N * 2^P; output frequency is that over R.
	// The one-cycle lag is the price of clean levels on the analog side.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loopSettings <= '0;
		end else begin
			loopSettings.pllEnable <= pllPowerOn & ~linearZero;
			loopSettings.effMultiplier <= eff_mult(settings.multiplier);
			loopSettings.effRefDivider <= eff_div(settings.refDivider);
			loopSettings.feedbackRatio <=
				RATIO_W'(eff_mult(settings.multiplier)) << settings.prescaler;
			loopSettings.prescaler <= settings.prescaler;
			loopSettings.rangePower <= settings.rangePower;
			loopSettings.linearRange <= settings.linearRange;
		end
	end

	// Transition logic and divide by two.
	// The raw select bit is the request; the switch synchronises it into both
	// source domains and gates each source only in its low phase. The output
	// is a divide by two, so the bus clock is half the source.
	pbc_clock_switch u_switch (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.crystalClock(crystalClock),
		.vcoClock(vcoClock),
		.selectVco(baseClockSelect),
		.baseClockOut(baseClockOut),
		.activeVco(vcoActive),
		.switching(switchBusy)
	);

endmodule : pbc_base_clock_selector

// [rtl/pbc_clock_switch.sv]
// Glitch-free switch between crystal and VCO clock levels, followed by a divide by two
`timescale 1ns/1ps
module pbc_clock_switch (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic crystalClock,
	input wire logic vcoClock,
	input wire logic selectVco,
	output logic baseClockOut,
	output logic activeVco,
	output logic switching
);
	import pbc_pkg::*;

	typedef enum logic [1:0] {PBC_RUN, PBC_WAIT} pbc_sw_state_t;

	pbc_sw_state_t state;
	logic crystalPrev;
	logic vcoPrev;
	logic selCrystal;
	logic selVco;
	logic [1:0] crystalCount;
	logic [1:0] vcoCount;
	logic crystalRise;
	logic vcoRise;
	logic oldLow;
	logic newLow;
	logic countsDone;

	// Edge detection on the source levels
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crystalPrev <= 1'b0;
			vcoPrev <= 1'b0;
		end else begin
			crystalPrev <= crystalClock;
			vcoPrev <= vcoClock;
		end
	end

	assign crystalRise = crystalClock & ~crystalPrev;
	assign vcoRise = vcoClock & ~vcoPrev;
	assign oldLow = activeVco ? ~vcoClock : ~crystalClock;
	assign newLow = selVco ? ~vcoClock : ~crystalClock;
	assign countsDone = (crystalCount == SWITCH_EDGES) && (vcoCount == SWITCH_EDGES);
	assign switching = (state == PBC_WAIT);

	// Request captured on the crystal's rising edge, and that copy passed on at the VCO's rising edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			selCrystal <= 1'b0;
			selVco <= 1'b0;
		end else begin
			if (crystalRise) begin
				selCrystal <= selectVco;
			end
			if (vcoRise) begin
				selVco <= selCrystal;
			end
		end
	end

	// Switch-over sequence; the old source is gated off only while it is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= PBC_RUN;
			activeVco <= 1'b0;
			crystalCount <= 2'h0;
			vcoCount <= 2'h0;
		end else begin
			case (state)
				PBC_RUN: begin
					crystalCount <= 2'h0;
					vcoCount <= 2'h0;
					if ((selVco != activeVco) && oldLow) begin
						state <= PBC_WAIT;
					end
				end
				PBC_WAIT: begin
					if (crystalRise && crystalCount != SWITCH_EDGES) begin
						crystalCount <= crystalCount + 2'h1;
					end
					if (vcoRise && vcoCount != SWITCH_EDGES) begin
						vcoCount <= vcoCount + 2'h1;
					end
					// New source enters on its low phase so no runt pulse appears
					if (countsDone && newLow) begin
						activeVco <= selVco;
						state <= PBC_RUN;
					end
				end
				default: begin
					state <= PBC_RUN;
				end
			endcase
		end
	end

	// Divide by two; held static while the switch is in progress
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baseClockOut <= 1'b0;
		end else if (state == PBC_RUN && (activeVco ? vcoRise : crystalRise)) begin
			baseClockOut <= ~baseClockOut;
		end
	end

endmodule : pbc_clock_switch

// [rtl/pbc_pkg.sv]
// Package for the PLL base clock selector: field widths, reset values, carriers
package pbc_pkg;

	// Field widths of the PLL programming values
	localparam int PRESCALE_W = 2;
	localparam int RANGE_POW_W = 2;
	localparam int MULT_W = 12;
	localparam int MULT_HIGH_W = 4;
	localparam int LINEAR_W = 8;
	localparam int REFDIV_W = 4;
	localparam int BYTE_W = 8;
	localparam int RATIO_W = 15;

	// Field positions of the multiplier halves
	localparam int MULT_LOW_LSB = 0;
	localparam int MULT_HIGH_LSB = 8;

	// Reset values of the programming values and the control bits
	localparam logic RST_POWER_ON = 1'h1;
	localparam logic RST_BASE_SELECT = 1'h0;
	localparam logic [PRESCALE_W-1:0] RST_PRESCALE = 2'h0;
	localparam logic [RANGE_POW_W-1:0] RST_RANGE_POW = 2'h0;
	localparam logic [MULT_W-1:0] RST_MULT = 12'h040;
	localparam logic [LINEAR_W-1:0] RST_LINEAR = 8'h40;
	localparam logic [REFDIV_W-1:0] RST_REFDIV = 4'h1;

	// Source clock edges to wait for on each side during a switch-over
	localparam logic [1:0] SWITCH_EDGES = 2'h3;

	// Write into the control register
	typedef struct packed {
		logic pllPowerOn;
		logic baseClockSelect;
		logic [PRESCALE_W-1:0] prescaler;
		logic [RANGE_POW_W-1:0] rangePower;
	} pbc_ctrl_t;

	// Stored PLL programming values
	typedef struct packed {
		logic [PRESCALE_W-1:0] prescaler;
		logic [RANGE_POW_W-1:0] rangePower;
		logic [MULT_W-1:0] multiplier;
		logic [LINEAR_W-1:0] linearRange;
		logic [REFDIV_W-1:0] refDivider;
	} pbc_settings_t;

	// Settings as the analog loop should use them
	typedef struct packed {
		logic pllEnable;
		logic [MULT_W-1:0] effMultiplier;
		logic [REFDIV_W-1:0] effRefDivider;
		logic [RATIO_W-1:0] feedbackRatio;
		logic [PRESCALE_W-1:0] prescaler;
		logic [RANGE_POW_W-1:0] rangePower;
		logic [LINEAR_W-1:0] linearRange;
	} pbc_loop_t;

endpackage : pbc_pkg

// [tb/pbc_base_clock_selector_bench.sv]
// Self-checking bench for the PLL base clock selector
`timescale 1ns/1ps
module pbc_base_clock_selector_bench;
	import pbc_pkg::*;
	logic clk_sys = 1'h0, rst_n = 1'h0, crystalClock = 1'h0, vcoClock = 1'h0, ctrlWrite = 1'h0;
	logic multLowWrite = 1'h0, multHighWrite = 1'h0, rangeWrite = 1'h0, refDivWrite = 1'h0;
	pbc_ctrl_t ctrlData = '0, ctrlRead;
	logic [BYTE_W-1:0] writeData = 8'h00, multLowRead, multHighRead, rangeRead, refDivRead;
	pbc_loop_t loopSettings;
	logic baseClockOut, vcoActive, switchBusy;
	int err_count = 0, cmp_count = 0, cyc = 0, i;
	int edgeCount;
	int on = 1, sel = 0, mP = 0, mE = 0, mN = 'h40, mL = 'h40, mR = 1;
	pbc_base_clock_selector uut (.clk_sys, .rst_n, .crystalClock, .vcoClock, .ctrlWrite,
		.ctrlData, .multLowWrite, .multHighWrite, .rangeWrite, .refDivWrite, .writeData,
		.ctrlRead, .multLowRead, .multHighRead, .rangeRead, .refDivRead, .loopSettings,
		.baseClockOut, .vcoActive, .switchBusy);
	pbc_clock_sink sink (.clk_sys, .baseClockOut, .edgeCount);
	always #10 clk_sys = ~clk_sys;
	// Sources at clk/6 and clk/10, slow enough to be sampled; cycle ceiling cuts a hang
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		crystalClock <= (cyc % 6) < 3;
		vcoClock <= (cyc % 10) < 5;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	task automatic ck(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : ck
	task automatic final_report;
		$display("Compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// Compare registers and loop settings with the model
	task automatic chk;
		int n, r;
		n = (mN == 0) ? 1 : mN;
		r = (mR == 0) ? 1 : mR;
		ck({on[0] | sel[0], sel[0], mP[1:0], mE[1:0]}, ctrlRead);
		ck({multHighRead, multLowRead, rangeRead, refDivRead},
			{4'h0, mN[11:0], mL[7:0], 4'h0, mR[3:0]});
		ck(loopSettings, {on[0] && mL != 0, n[11:0], r[3:0],
			15'(n << mP), mP[1:0], mE[1:0], mL[7:0]});
	endtask : chk
	// Write kind k: 0 control, 1 low, 2 high, 3 range, 4 divider
	task automatic wr(input int k, input logic [7:0] d);
		@(posedge clk_sys);
		{refDivWrite, rangeWrite, multHighWrite, multLowWrite, ctrlWrite} <= 5'(1 << k);
		writeData <= d;
		ctrlData <= pbc_ctrl_t'(d[5:0]);
		@(posedge clk_sys);
		{refDivWrite, rangeWrite, multHighWrite, multLowWrite, ctrlWrite} <= 5'h00;
		if (k == 0) begin
			if (on == 0) begin
				mP = d[3:2];
				mE = d[1:0];
			end
			// A refused power-off leaves the write free to move the select
			if (d[5] != on[0] && sel == 0) on = d[5];
			else sel = d[4] && on != 0 && mL != 0;
		end else if (on == 0) begin
			if (k == 1) mN[7:0] = d;
			else if (k == 2) mN[11:8] = d[3:0];
			else if (k == 3) mL = d;
			else mR = d[3:0];
		end
		sel = sel && on != 0 && mL != 0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk();
	endtask : wr
	// Wait out a switch-over and check its length and the new source
	task automatic sw(input int v);
		int j;
		i = 0;
		j = 0;
		while (switchBusy !== 1'h1 && i < 400) begin
			@(posedge clk_sys);
			i++;
		end
		while (switchBusy !== 1'h0 && j < 400) begin
			@(posedge clk_sys);
			j++;
		end
		@(negedge clk_sys);
		ck({i < 400, j >= 20 && j <= 60, vcoActive}, {2'h3, v[0]});
	endtask : sw
	task automatic fr(input int e);
		int c;
		c = edgeCount;
		repeat (300) @(posedge clk_sys);
		ck(edgeCount - c >= e - 1 && edgeCount - c <= e + 1, 1'h1);
	endtask : fr
	initial begin
		void'($urandom(73));
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (2) @(negedge clk_sys);
		chk();
		fr(50);
		$display("Test reset and crystal clock done");
		wr(1, 8'h12);
		wr(0, 8'h00);
		wr(0, 8'h1E);
		// Random programming with zeros mixed in, range power kept below 3
		for (i = 0; i < 16; i++) begin
			wr(1 + $urandom % 4, (i % 4 == 0) ? 8'h00 : 8'($urandom));
			wr(0, {4'h0, 2'($urandom), 2'($urandom % 3)});
		end
		$display("Test programming done");
		wr(3, 8'h00);
		wr(0, 8'h20);
		wr(0, 8'h30);
		wr(0, 8'h00);
		wr(3, 8'h40);
		wr(0, 8'h30);
		wr(0, 8'h30);
		sw(1);
		fr(30);
		wr(0, 8'h10);
		$display("Test VCO selection done");
		wr(0, 8'h20);
		sw(0);
		fr(50);
		wr(0, 8'h00);
		$display("Test crystal return done");
		final_report();
	end
endmodule : pbc_base_clock_selector_bench

// [tb/pbc_clock_sink.sv]
// Bus clock consumer model: counts base clock transitions
`timescale 1ns/1ps
module pbc_clock_sink (
	input wire logic clk_sys,
	input wire logic baseClockOut,
	output int edgeCount
);
	logic lastLevel = 1'h0;
	// Each level change is one rising edge of the selected source
	always @(posedge clk_sys) begin
		if (baseClockOut !== lastLevel) edgeCount <= edgeCount + 1;
		lastLevel <= baseClockOut;
	end
endmodule : pbc_clock_sink

// [tb/pbc_selector_chk.sv]
// Port checker for the PLL base clock selector
`timescale 1ns/1ps
module pbc_selector_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ctrlWrite,
	input wire pbc_pkg::pbc_ctrl_t ctrlData,
	input wire logic multLowWrite,
	input wire pbc_pkg::pbc_ctrl_t ctrlRead,
	input wire logic [pbc_pkg::BYTE_W-1:0] multLowRead,
	input wire logic [pbc_pkg::BYTE_W-1:0] rangeRead,
	input wire logic [pbc_pkg::BYTE_W-1:0] refDivRead,
	input wire pbc_pkg::pbc_loop_t loopSettings,
	input wire logic baseClockOut,
	input wire logic vcoActive,
	input wire logic switchBusy
);
	import pbc_pkg::*;
	// One domain, so one clock and one reset for every property
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_sel_power: assert property (ctrlRead.baseClockSelect |-> ctrlRead.pllPowerOn &&
		loopSettings.pllEnable) else $error("Select set with power off");
	a_sel_range: assert property (ctrlRead.baseClockSelect |-> rangeRead != 8'h00)
		else $error("Select set with zero range");
	a_sel_refused: assert property (ctrlWrite && ctrlData.baseClockSelect &&
		!ctrlRead.pllPowerOn |=> !ctrlRead.baseClockSelect) else $error("Select taken while off");
	a_off_refused: assert property (ctrlWrite && ctrlRead.baseClockSelect
		|=> ctrlRead.pllPowerOn ##1 loopSettings.pllEnable)
		else $error("Power dropped while selected");
	a_power_keeps: assert property (ctrlWrite && !ctrlRead.baseClockSelect &&
		(ctrlData.pllPowerOn != ctrlRead.pllPowerOn) |=> $stable(ctrlRead.baseClockSelect))
		else $error("Select moved");
	a_frozen_low: assert property (ctrlRead.pllPowerOn && multLowWrite |=>
		$stable(multLowRead)) else $error("Multiplier written while on");
	a_held_busy: assert property (switchBusy ##1 switchBusy |-> $stable(baseClockOut))
		else $error("Base clock moved during switch");
	a_switch_end: assert property ($fell(switchBusy) |-> ##[0:1]
		vcoActive == ctrlRead.baseClockSelect) else $error("Wrong source after switch");
	a_loop_enable: assert property ($past(rst_n) |-> loopSettings.pllEnable ==
		$past(ctrlRead.pllPowerOn && rangeRead != 8'h00)) else $error("Loop enable wrong");
	a_ref_one: assert property ($past(rst_n) |-> loopSettings.effRefDivider ==
		($past(refDivRead[3:0]) == 4'h0 ? 4'h1 : $past(refDivRead[3:0])))
		else $error("Divider zero not read as one");
	a_ratio: assert property (loopSettings.feedbackRatio ==
		(RATIO_W'(loopSettings.effMultiplier) << loopSettings.prescaler)) else $error("Ratio");
	c_switch: cover property ($rose(switchBusy));
	c_vco: cover property ($rose(vcoActive));
	c_refused: cover property (ctrlWrite && ctrlData.baseClockSelect && !ctrlRead.pllPowerOn);
endmodule : pbc_selector_chk

bind pbc_base_clock_selector pbc_selector_chk chk (.clk_sys, .rst_n, .ctrlWrite, .ctrlData,
	.multLowWrite, .ctrlRead, .multLowRead, .rangeRead, .refDivRead, .loopSettings,
	.baseClockOut, .vcoActive, .switchBusy);
